//--- rtl/cmd_fifo.sv
// Parameterised valid/ready FIFO for queued controller commands.
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    // The pointer arithmetic only wraps correctly for powers of two.
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_check
        $error("cmd_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [PW:0] fill = wr_ptr - rd_ptr;
    assign in_ready = fill != (PW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[PW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr[PW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (PW+1)'(push);
            rd_ptr <= rd_ptr + (PW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

//--- rtl/sram_cmd_device.sv
// Memory end: samples commands on qualified edges and tracks the burst.
`timescale 1ns/1ps
`default_nettype none
module sram_cmd_device
    import sram_ctl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    sram_ctl_if.device link,
    output logic selected,
    output logic write_active,
    output logic [ADDR_W-1:0] cur_addr,
    output logic [LANES-1:0] lane_write_en,
    output logic [DATA_W-1:0] write_data,
    output logic write_valid
);
    import sram_ctl_pkg::*;
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pins arrive from another chip, so every one passes two stages.
    logic [ADDR_W+LANES+6+DATA_W-1:0] sync_a;
    logic [ADDR_W+LANES+6+DATA_W-1:0] sync_b;
    wire [ADDR_W+LANES+6+DATA_W-1:0] pins = {link.addr,
        link.lane_write_sel_n, link.write_strobe_n, link.burst_step_or_load,
        link.clock_qualifier_n, link.select_first_n, link.select_second,
        link.select_third_n, link.data_bus};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pins;
            sync_b <= sync_a;
        end
    end
    wire [ADDR_W-1:0] s_addr = sync_b[DATA_W+LANES+6 +: ADDR_W];
    wire [LANES-1:0] s_lanes_n = sync_b[DATA_W+6 +: LANES];
    wire s_we_n = sync_b[DATA_W+5];
    wire s_step = sync_b[DATA_W+4];
    wire s_qual_n = sync_b[DATA_W+3];
    wire s_sel1_n = sync_b[DATA_W+2];
    wire s_sel2 = sync_b[DATA_W+1];
    wire s_sel3_n = sync_b[DATA_W];
    wire [DATA_W-1:0] s_data = sync_b[DATA_W-1:0];

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire edge_ok = !s_qual_n;
    wire sel_now = !s_sel1_n && s_sel2 && !s_sel3_n;
    wire do_step = s_step && selected;
    wire do_write = sel_now && !s_we_n && !s_step;
    logic interleave;
    logic interleave_meta;
    logic [ADDR_W-1:0] base_addr;
    logic [1:0] beat;
    cyc_t cyc;
    cyc_t next_cyc;
    logic resumed;
    assign next_cyc = do_step ? cyc
                    : (!sel_now ? CYC_DESELECT
                    : (do_write ? CYC_WRITE : CYC_READ));
    wire [1:0] next_low = burst_next(base_addr[1:0], beat, interleave);

    // ------------------------------------------------------------
    // Qualified state
    // ------------------------------------------------------------
    // Burst order is resampled through two stages on every edge; changing it mid-burst is unsafe.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            interleave <= 1'b1;
            interleave_meta <= 1'b1;
            selected <= 1'b0;
            cyc <= CYC_DESELECT;
            base_addr <= '0;
            cur_addr <= '0;
            beat <= 2'h0;
            resumed <= 1'b0;
            write_active <= 1'b0;
            lane_write_en <= '0;
            write_data <= '0;
            write_valid <= 1'b0;
        end else begin
            interleave_meta <= link.burst_interleave;
            interleave <= interleave_meta;
            write_valid <= 1'b0;
            if (edge_ok) begin
                cyc <= next_cyc;
                selected <= next_cyc != CYC_DESELECT;
                resumed <= cyc == CYC_DESELECT && next_cyc != CYC_DESELECT;
                write_active <= next_cyc == CYC_WRITE;
                if (do_step) begin
                    beat <= beat + BURST_ONE;
                    cur_addr <= {base_addr[ADDR_W-1:2], next_low};
                end else if (sel_now) begin
                    base_addr <= s_addr;
                    cur_addr <= s_addr;
                    beat <= 2'h0;
                end
                if (next_cyc == CYC_WRITE) begin
                    lane_write_en <= ~s_lanes_n;
                    write_data <= s_data;
                    write_valid <= 1'b1;
                end else begin
                    lane_write_en <= '0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------
    // Drive only in a settled read; writes, deselect and resume float.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link.dev_data_oe <= 1'b0;
            link.dev_data <= '0;
        end else begin
            link.dev_data_oe <= cyc == CYC_READ && !resumed;
            link.dev_data <= '0;
        end
    end
endmodule
`default_nettype wire

//--- rtl/sram_cmd_host.sv
// Controller end: queues commands and drives them onto the memory pins.
`timescale 1ns/1ps
`default_nettype none
module sram_cmd_host
    import sram_ctl_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    sram_ctl_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_step,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [LANES-1:0] cmd_lanes_n,
    input wire logic [DATA_W-1:0] cmd_data,
    input wire logic hold,
    input wire logic interleave
);
    import sram_ctl_pkg::*;
    cmd_t in_cmd;
    cmd_t q_cmd;
    logic q_valid;
    logic was_deselect;
    assign in_cmd = '{write: cmd_write, step: cmd_step, addr: cmd_addr,
                      lanes_n: cmd_lanes_n, data: cmd_data};
    // Holding the qualifier stalls the queue, so back-pressure reaches users.
    wire take = q_valid && !hold;
    cmd_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(in_cmd),
        .out_valid(q_valid),
        .out_ready(!hold),
        .out_data(q_cmd)
    );
    wire step_ok = q_cmd.step && !was_deselect;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link.addr <= '0;
            link.lane_write_sel_n <= LANES_OFF;
            link.write_strobe_n <= 1'b1;
            link.burst_step_or_load <= 1'b0;
            link.clock_qualifier_n <= 1'b0;
            link.select_first_n <= 1'b1;
            link.select_second <= 1'b0;
            link.select_third_n <= 1'b1;
            link.burst_interleave <= 1'b1;
            link.host_data <= '0;
            link.host_data_oe <= 1'b0;
            was_deselect <= 1'b1;
        end else begin
            link.burst_interleave <= interleave;
            link.clock_qualifier_n <= hold;
            if (!hold) begin
                link.select_first_n <= !take;
                link.select_second <= take;
                link.select_third_n <= !take;
                link.write_strobe_n <= !(take && q_cmd.write);
                link.burst_step_or_load <= take && step_ok;
                link.addr <= q_cmd.addr;
                link.lane_write_sel_n <= take && q_cmd.write ?
                                         q_cmd.lanes_n : LANES_OFF;
                link.host_data <= q_cmd.data;
                link.host_data_oe <= take && q_cmd.write;
                was_deselect <= !take;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/sram_ctl_if.sv
// Pin-level link between the memory controller and the memory command front end.
`timescale 1ns/1ps
`default_nettype none
interface sram_ctl_if;
    import sram_ctl_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_write_sel_n;
    logic write_strobe_n;
    logic burst_step_or_load;
    logic clock_qualifier_n;
    logic select_first_n;
    logic select_second;
    logic select_third_n;
    logic burst_interleave;
    logic [DATA_W-1:0] host_data;
    logic host_data_oe;
    logic [DATA_W-1:0] dev_data;
    logic dev_data_oe;
    wire [DATA_W-1:0] data_bus = dev_data_oe ? dev_data : host_data;

    modport device (
        input addr, lane_write_sel_n, write_strobe_n, burst_step_or_load,
        input clock_qualifier_n, select_first_n, select_second,
        input select_third_n, burst_interleave, data_bus,
        output dev_data, dev_data_oe
    );
    modport host (
        output addr, lane_write_sel_n, write_strobe_n, burst_step_or_load,
        output clock_qualifier_n, select_first_n, select_second,
        output select_third_n, burst_interleave, host_data, host_data_oe,
        input data_bus
    );
endinterface
`default_nettype wire

//--- rtl/sram_ctl_pkg.sv
// Constants and types shared by both ends of the static memory command link.
//
// Summary of operation
// - Address captured only at rising clock edge.
// - All synchronous inputs registered on qualified edges; the memory end resamples burst order on every edge.
// - Edges ignored while clock qualifier is high.
// - Active-low lane selects act only with strobe.
// - Write strobe sampled only on qualified edges.
// - Controller holds strobe low to start write.
// - Advance high increments the burst counter.
// - Advance low loads the presented address.
// - Controller loads fresh address after deselect.
// - First select active low, sampled on edge.
// - Second select active high, sampled on edge.
// - Third select active low, sampled on edge.
// - Qualifier high holds state, never deselects.
// - Burst order interleaved when high, linear low.
// - Data outputs float on write, deselect, resume.
package sram_ctl_pkg;
    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int BYTE_W = 9;
    localparam int DATA_W = LANES * BYTE_W;
    localparam logic [1:0] BURST_ONE = 2'h1;
    localparam logic [2:0] CMD_IDLE = 3'h0;
    localparam logic [LANES-1:0] LANES_OFF = 4'hf;

    typedef enum logic [1:0] {
        CYC_DESELECT = 2'b00,
        CYC_READ = 2'b01,
        CYC_WRITE = 2'b10
    } cyc_t;

    typedef struct packed {
        logic write;
        logic step;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lanes_n;
        logic [DATA_W-1:0] data;
    } cmd_t;

    // Next burst address in the two low bits.
    function automatic logic [1:0] burst_next(input logic [1:0] start,
                                              input logic [1:0] count,
                                              input logic interleave);
        logic [1:0] c;
        c = count + BURST_ONE;
        return interleave ? (start ^ c) : (start + c);
    endfunction
endpackage

//--- test/sram_ctl_asserts.sv
// Concurrent checks on the memory command link and the memory end.
`timescale 1ns/1ps
`default_nettype none
module sram_ctl_asserts
    import sram_ctl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES-1:0] lane_write_sel_n,
    input wire logic write_strobe_n,
    input wire logic burst_step_or_load,
    input wire logic clock_qualifier_n,
    input wire logic select_first_n,
    input wire logic select_second,
    input wire logic select_third_n,
    input wire logic dev_data_oe,
    input wire logic selected,
    input wire logic write_active,
    input wire logic [ADDR_W-1:0] cur_addr,
    input wire logic [LANES-1:0] lane_write_en,
    input wire logic write_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // Pin decode and settling window
    // ----------------------------------------------------------------
    // The decode checks wait until the input pipe has refilled after reset or a hold.
    logic [2:0] up;
    logic [2:0] qh;
    wire sel_pins = !select_first_n && select_second && !select_third_n;
    wire desel = !sel_pins;
    wire ld = sel_pins && !burst_step_or_load;
    wire wr = ld && !write_strobe_n;
    wire nowr = write_strobe_n && !burst_step_or_load;
    wire stp = sel_pins && burst_step_or_load;
    wire ok = (up == 3'h7) && (&qh) && !clock_qualifier_n;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            up <= 3'h0;
            qh <= 3'h0;
        end else begin
            up <= (up == 3'h7) ? up : up + 3'h1;
            qh <= {qh[1:0], !clock_qualifier_n};
        end
    end
    a_select_decode: assert property (
        ok |-> selected == $past(sel_pins, 3))
        else $error("selected does not follow the selects");
    a_load_addr: assert property (
        ok && $past(ld, 3) |-> cur_addr == $past(addr, 3))
        else $error("load did not take the address");
    a_write_start: assert property (
        ok && $past(wr, 3) |-> write_valid &&
        lane_write_en == ~$past(lane_write_sel_n, 3))
        else $error("write or lanes wrong");
    a_no_write: assert property (
        ok && $past(nowr, 3) |-> !write_valid)
        else $error("write without strobe");
    a_burst_step: assert property (
        ok && $past(stp, 3) |->
        cur_addr[ADDR_W-1:2] == $past(cur_addr[ADDR_W-1:2]))
        else $error("step left the burst");
    a_hold_state: assert property (
        clock_qualifier_n [*4] |=> $stable(cur_addr) && $stable(selected))
        else $error("state moved during hold");
    a_oe_masked: assert property (
        dev_data_oe |-> $past(selected) && !$past(write_active))
        else $error("data driven on write or deselect");
    a_oe_resume: assert property (
        $past(selected) && !$past(selected, 2) |-> !dev_data_oe)
        else $error("data driven on resume");
    a_fresh_load: assert property (
        $past(desel) && sel_pins |-> !burst_step_or_load)
        else $error("step after deselect");
    c_write: cover property (ok && write_valid);
    c_hold: cover property (clock_qualifier_n [*4]);
    c_read: cover property (dev_data_oe);
endmodule
`default_nettype wire

//--- test/sync_sram_control_inputs_test.sv
// Self-checking bench joining the controller end to the memory end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module sync_sram_control_inputs_test;
    import sram_ctl_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_step = 1'b0;
    logic hold = 1'b0, interleave = 1'b1;
    logic [ADDR_W-1:0] cmd_addr = 18'h0;
    logic [LANES-1:0] cmd_lanes_n = 4'hf;
    logic [DATA_W-1:0] cmd_data = 36'h0;
    logic cmd_ready, selected, write_active, write_valid;
    logic [ADDR_W-1:0] cur_addr, got;
    logic [LANES-1:0] lane_write_en;
    logic [DATA_W-1:0] write_data;
    int num_errors = 0;
    int tests_run = 0;
    always #2.5 sys_clk = ~sys_clk;
    sram_ctl_if link();
    sram_cmd_host #(.FIFO_DEPTH(4)) u_sram_cmd_host (.sys_clk(sys_clk),
        .rst(rst), .link(link.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_step(cmd_step),
        .cmd_addr(cmd_addr), .cmd_lanes_n(cmd_lanes_n), .cmd_data(cmd_data),
        .hold(hold), .interleave(interleave));
    sram_cmd_device u_sram_cmd_device (.sys_clk(sys_clk), .rst(rst),
        .link(link.device), .selected(selected), .write_active(write_active),
        .cur_addr(cur_addr), .lane_write_en(lane_write_en),
        .write_data(write_data), .write_valid(write_valid));
    sram_ctl_asserts u_sram_ctl_asserts (.sys_clk(sys_clk), .rst(rst),
        .addr(link.addr), .lane_write_sel_n(link.lane_write_sel_n),
        .write_strobe_n(link.write_strobe_n),
        .burst_step_or_load(link.burst_step_or_load),
        .clock_qualifier_n(link.clock_qualifier_n),
        .select_first_n(link.select_first_n),
        .select_second(link.select_second),
        .select_third_n(link.select_third_n), .dev_data_oe(link.dev_data_oe),
        .selected(selected), .write_active(write_active),
        .cur_addr(cur_addr), .lane_write_en(lane_write_en),
        .write_valid(write_valid));
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Leaves valid high so back-to-back pushes never toggle it twice.
    task push(input logic w, input logic s, input logic [ADDR_W-1:0] a,
              input logic [LANES-1:0] l, input logic [DATA_W-1:0] d);
        int n;
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_step <= s;
        cmd_addr <= a;
        cmd_lanes_n <= l;
        cmd_data <= d;
        // Ready is looked at before the edge, where the handshake happens.
        for (n = 0; n < 50; n++) begin
            @(negedge sys_clk);
            if (cmd_ready === 1'b1) break;
            @(posedge sys_clk);
        end
        if (n == 50) begin
            num_errors++;
            report_and_stop;
        end
        @(posedge sys_clk);
    endtask
    task wait_wr(output logic [ADDR_W-1:0] a);
        int n;
        for (n = 0; n < 50; n++) begin
            @(negedge sys_clk);
            if (write_valid === 1'b1) break;
        end
        if (n == 50) begin
            num_errors++;
            report_and_stop;
        end
        a = cur_addr;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        push(1'b1, 1'b0, 18'h12345, 4'h5, 36'h123456789);
        cmd_valid <= 1'b0;
        wait_wr(got);
        `CHK(got, 18'h12345)
        `CHK(lane_write_en, 4'ha)
        `CHK(write_data, 36'h123456789)
        for (int m = 0; m < 2; m++) begin
            @(posedge sys_clk);
            interleave <= (m == 0) ? 1'b1 : 1'b0;
            repeat (4) @(posedge sys_clk);
            push(1'b1, 1'b0, 18'h00201, 4'h0, 36'h0);
            push(1'b1, 1'b1, 18'h0, 4'h0, 36'h0);
            push(1'b0, 1'b0, 18'h00300, 4'hf, 36'h0);
            cmd_valid <= 1'b0;
            wait_wr(got);
            `CHK(got, 18'h00201)
            wait_wr(got);
            `CHK(got, (m == 0) ? 18'h00200 : 18'h00202)
        end
        repeat (8) @(posedge sys_clk);
        push(1'b1, 1'b1, 18'h3a5c8, 4'h0, 36'h0);
        cmd_valid <= 1'b0;
        wait_wr(got);
        `CHK(got, 18'h3a5c8)
        @(posedge sys_clk);
        hold <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            push(1'b1, 1'b0, 18'(16 + k), 4'h0, 36'h0);
        end
        @(negedge sys_clk);
        `CHK(cmd_ready, 1'b0)
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        repeat (10) begin
            @(negedge sys_clk);
            `CHK(write_valid, 1'b0)
        end
        @(posedge sys_clk);
        hold <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wait_wr(got);
            `CHK(got, 18'(16 + k))
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
